// ### sbod_defines.vh
`ifndef SBOD_DEFINES_VH
`define SBOD_DEFINES_VH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SBOD_OFF_DEBUG_ACCESS   8'h00
`define SBOD_OFF_PROTECT_ENABLE 8'h04
`define SBOD_OFF_STARTUP_BANK   8'h08
`define SBOD_OFF_BANK_MAP       8'h0C
`define SBOD_OFF_STATUS         8'h10
// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define SBOD_PROT_MSB           30
`define SBOD_PROT_LSB           28
`define SBOD_SWAP_MSB           2
`define SBOD_SWAP_LSB           0
`define SBOD_DBG_BIT            0
`define SBOD_CODE_ON            3'h0
`define SBOD_CODE_OFF           3'h7
// ----------------------------------------------------------------
// bank windows, upper 16 address bits
// ----------------------------------------------------------------
`define SBOD_BIG_HI_BASE        16'hFFE0
`define SBOD_BIG_LO_BASE        16'hFFC0
`define SBOD_SML_HI_BASE        16'hFFF0
`define SBOD_SML_LO_BASE        16'hFFE0
`define SBOD_BIG_BLK_A          8'h4E
`define SBOD_BIG_BLK_B          8'h4F
`define SBOD_SML_BLK_A          8'h2E
`define SBOD_SML_BLK_B          8'h2F
// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define SBOD_RESP_OKAY          2'h0
`define SBOD_RESP_SLVERR        2'h2
`endif

// ### sbod_startup_bank_option_decode.v
`timescale 1ns/1ps
`include "sbod_defines.vh"
// Notes on behaviour
// - large variant: protection field 000 enables protection of blocks 78,79
// - small variant: protection field 000 enables protection of blocks 46,47
// - either variant: protection field 111 disables dual-mode protection
// - large, swap 000: bank1 at FFE00000, bank0 at FFC00000
// - large, swap 111: bank1 at FFC00000, bank0 at FFE00000
// - small, swap 000: bank1 at FFF00000, bank0 at FFE00000
// - small, swap 111: bank1 at FFE00000, bank0 at FFF00000
// - small variant only: debugger connect enable option bit
module sbod_startup_bank_option_decode #(
    // 1 fits the smaller flash, 0 the larger one with lower windows
    parameter SMALL_FLASH = 1
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [31:0] debug_access_option,
    input  wire [31:0] protect_enable_option,
    input  wire [31:0] startup_bank_option,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        flash_access_protection,
    output wire        startup_bank_swapped,
    output wire        debugger_connect_enable,
    output wire [15:0] bank0_base_hi,
    output wire [15:0] bank1_base_hi,
    output wire        option_code_error
);

// ----------------------------------------------------------------
// option capture
// ----------------------------------------------------------------
// capture flag and raw option words, readable over the bus
reg        loaded_ff;
reg [31:0] dbg_word_ff;
reg [31:0] prot_word_ff;
reg [31:0] bank_word_ff;
// decoded settings, each drives one output pin directly
reg        prot_on_ff;
reg        swap_ff;
reg        dbg_en_ff;
reg [15:0] b0_ff;
reg [15:0] b1_ff;
reg        err_ff;

// the two three-bit codes under decode
wire [2:0] prot_field = protect_enable_option[`SBOD_PROT_MSB:`SBOD_PROT_LSB];
wire [2:0] swap_field = startup_bank_option[`SBOD_SWAP_MSB:`SBOD_SWAP_LSB];
// any code besides 000 and 111 is flagged, decoded as safest value
wire nxt_err = ((prot_field != `SBOD_CODE_ON) &&
                (prot_field != `SBOD_CODE_OFF)) ||
               ((swap_field != `SBOD_CODE_ON) &&
                (swap_field != `SBOD_CODE_OFF));
// illegal protection code keeps protection on; illegal swap means no swap
wire nxt_prot_on = (prot_field != `SBOD_CODE_OFF);
wire nxt_swap    = (swap_field == `SBOD_CODE_OFF);
// window bases of the fitted variant; the larger flash starts lower
wire [15:0] hi_base = SMALL_FLASH ? `SBOD_SML_HI_BASE : `SBOD_BIG_HI_BASE;
wire [15:0] lo_base = SMALL_FLASH ? `SBOD_SML_LO_BASE : `SBOD_BIG_LO_BASE;

// sampled in the first cycle after release only, then frozen
// later changes of the option words cannot reach the outputs
always @(posedge aclk) begin
    if (!aresetn) begin
        loaded_ff    <= 1'b0;
        dbg_word_ff  <= 32'h0000_0000;
        prot_word_ff <= 32'h0000_0000;
        bank_word_ff <= 32'h0000_0000;
        // protection defaults on, so nothing is exposed before the load
        prot_on_ff   <= 1'b1;
        swap_ff      <= 1'b0;
        dbg_en_ff    <= 1'b0;
        b0_ff        <= 16'h0000;
        b1_ff        <= 16'h0000;
        err_ff       <= 1'b0;
    end else if (!loaded_ff) begin
        loaded_ff    <= 1'b1;
        dbg_word_ff  <= SMALL_FLASH ? debug_access_option : 32'h0000_0000;
        prot_word_ff <= protect_enable_option;
        bank_word_ff <= startup_bank_option;
        prot_on_ff   <= nxt_prot_on;
        swap_ff      <= nxt_swap;
        // polarity kept as stored, large variant has no bit
        dbg_en_ff    <= SMALL_FLASH ?
                        debug_access_option[`SBOD_DBG_BIT] : 1'b0;
        b1_ff        <= nxt_swap ? lo_base : hi_base;
        b0_ff        <= nxt_swap ? hi_base : lo_base;
        err_ff       <= nxt_err;
    end
end

// decoded settings leave straight from their flops
assign flash_access_protection = prot_on_ff;
assign startup_bank_swapped    = swap_ff;
assign debugger_connect_enable = dbg_en_ff;
assign bank0_base_hi           = b0_ff;
assign bank1_base_hi           = b1_ff;
assign option_code_error       = err_ff;

// ----------------------------------------------------------------
// axi4-lite write side: all registers read-only, writes get slverr
// ----------------------------------------------------------------
// per-channel capture flags and handshake flops
reg       aw_got_ff;
reg       w_got_ff;
reg       bvalid_ff;
reg       awready_ff;
reg       wready_ff;
reg [1:0] bresp_ff;

// ready flags pulse every other idle cycle; the response waits for
// both halves, so a master may offer address and data in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_got_ff  <= 1'b0;
        w_got_ff   <= 1'b0;
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b0;
        wready_ff  <= 1'b0;
        bresp_ff   <= `SBOD_RESP_SLVERR;
    end else begin
        awready_ff <= !aw_got_ff && !bvalid_ff && !awready_ff;
        wready_ff  <= !w_got_ff && !bvalid_ff && !wready_ff;
        if (s_axi_awvalid && awready_ff)
            aw_got_ff <= 1'b1;
        if (s_axi_wvalid && wready_ff)
            w_got_ff <= 1'b1;
        if (aw_got_ff && w_got_ff && !bvalid_ff) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= `SBOD_RESP_SLVERR; // every write refused
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end
end

// write channel outputs, all from flops
assign s_axi_awready = awready_ff;
assign s_axi_wready  = wready_ff;
assign s_axi_bvalid  = bvalid_ff;
assign s_axi_bresp   = bresp_ff; // read-only block, no write target

// ----------------------------------------------------------------
// axi4-lite read side
// ----------------------------------------------------------------
// read handshake and the answer held until rready
reg        arready_ff;
reg        rvalid_ff;
reg [31:0] rdata_ff;
reg [1:0]  rresp_ff;
reg [31:0] nxt_rdata;
reg [1:0]  nxt_rresp;

// read map, one word each:
//   00 debug option word, zero on the larger flash
//   04 protection option word
//   08 startup bank option word
//   0C bank1 base in the upper half, bank0 base in the lower
//   10 status: error, debug enable, swap, protection on, loaded
// decode on the low byte, upper address bits ignored; araddr is
// decoded live, so it must stand until the handshake edge
always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `SBOD_RESP_OKAY;
    case (s_axi_araddr[7:0])
        `SBOD_OFF_DEBUG_ACCESS:   nxt_rdata = dbg_word_ff;
        `SBOD_OFF_PROTECT_ENABLE: nxt_rdata = prot_word_ff;
        `SBOD_OFF_STARTUP_BANK:   nxt_rdata = bank_word_ff;
        `SBOD_OFF_BANK_MAP:       nxt_rdata = {b1_ff, b0_ff};
        `SBOD_OFF_STATUS:         nxt_rdata = {27'h0, err_ff, dbg_en_ff,
                                               swap_ff, prot_on_ff,
                                               loaded_ff};
        default:                  nxt_rresp = `SBOD_RESP_SLVERR;
    endcase
end

// one read in flight: arready stays low until the data is taken
always @(posedge aclk) begin
    if (!aresetn) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b0;
        rdata_ff   <= 32'h0000_0000;
        rresp_ff   <= `SBOD_RESP_OKAY;
    end else begin
        arready_ff <= !rvalid_ff && !arready_ff;
        if (s_axi_arvalid && arready_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
end

// read channel outputs
assign s_axi_arready = arready_ff;
assign s_axi_rvalid  = rvalid_ff;
assign s_axi_rdata   = rdata_ff;
assign s_axi_rresp   = rresp_ff;

endmodule

// ### sbod_asserts.sv
`timescale 1ns/1ps
module sbod_asserts #(parameter SMALL_FLASH = 1) (
    input wire        aclk,
    input wire        aresetn,
    input wire [31:0] debug_access_option,
    input wire [31:0] protect_enable_option,
    input wire [31:0] startup_bank_option,
    input wire        flash_access_protection,
    input wire        startup_bank_swapped,
    input wire        debugger_connect_enable,
    input wire [15:0] bank0_base_hi,
    input wire [15:0] bank1_base_hi,
    input wire        option_code_error
);
    localparam [15:0] HI = SMALL_FLASH ? 16'hFFF0 : 16'hFFE0;
    localparam [15:0] LO = SMALL_FLASH ? 16'hFFE0 : 16'hFFC0;
    reg       rdy_ff;
    reg [2:0] pc_ff;
    reg [2:0] sc_ff;
    reg       dc_ff;
    // own copy of the words, so later input changes cannot hide a slip
    always @(posedge aclk) begin
        rdy_ff <= aresetn;
        if (aresetn && !rdy_ff) begin
            pc_ff <= protect_enable_option[30:28];
            sc_ff <= startup_bank_option[2:0];
            dc_ff <= debug_access_option[0];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_prot_on: assert property (rdy_ff && pc_ff == 3'h0 |->
        flash_access_protection) else $error("protection not on");
    a_prot_off: assert property (rdy_ff && pc_ff == 3'h7 |->
        !flash_access_protection) else $error("protection not off");
    a_map_plain: assert property (rdy_ff && sc_ff == 3'h0 |->
        bank1_base_hi == HI && bank0_base_hi == LO) else $error("plain map");
    a_map_swap: assert property (rdy_ff && sc_ff == 3'h7 |->
        bank1_base_hi == LO && bank0_base_hi == HI) else $error("swap map");
    a_swap_flag: assert property (rdy_ff |->
        startup_bank_swapped == (sc_ff == 3'h7)) else $error("swap flag");
    a_dbg_copy: assert property (rdy_ff |-> debugger_connect_enable ==
        (SMALL_FLASH ? dc_ff : 1'h0)) else $error("debug enable");
    a_map_hold: assert property (rdy_ff && $past(rdy_ff) |->
        $stable(bank0_base_hi) && $stable(bank1_base_hi)
        && $stable(flash_access_protection)) else $error("map moved");
    a_code_err: assert property (rdy_ff |-> option_code_error ==
        !((&pc_ff | ~|pc_ff) & (&sc_ff | ~|sc_ff))) else $error("code err");
endmodule
bind sbod_startup_bank_option_decode sbod_asserts
    #(.SMALL_FLASH(SMALL_FLASH)) u_chk (.*);

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg         aclk = 1'h0;
    reg         aresetn = 1'h0;
    reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    reg  [31:0] debug_access_option = 32'h0, protect_enable_option = 32'h0;
    reg  [31:0] startup_bank_option = 32'h0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire        s_axi_rvalid, flash_access_protection, startup_bank_swapped;
    wire        debugger_connect_enable, option_code_error;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] bank0_base_hi, bank1_base_hi;
    wire        big_prot, big_swap, big_dbg, big_err;
    wire [15:0] big_bank0, big_bank1;
    integer     bad_count = 0, comparisons = 0;
    reg  [31:0] q;
    reg  [1:0]  qr;
    // strobes are ignored by the slave, so all lanes stay on
    sbod_startup_bank_option_decode dut (.s_axi_wstrb(4'hF), .*);
    // larger-flash variant fed the same words; its bus answers go unused
    sbod_startup_bank_option_decode #(
        .SMALL_FLASH (0)
    ) dut_big (
        .aclk                    (aclk),
        .aresetn                 (aresetn),
        .debug_access_option     (debug_access_option),
        .protect_enable_option   (protect_enable_option),
        .startup_bank_option     (startup_bank_option),
        .s_axi_awaddr            (s_axi_awaddr),
        .s_axi_awvalid           (s_axi_awvalid),
        .s_axi_awready           (),
        .s_axi_wdata             (s_axi_wdata),
        .s_axi_wstrb             (4'hF),
        .s_axi_wvalid            (s_axi_wvalid),
        .s_axi_wready            (),
        .s_axi_bresp             (),
        .s_axi_bvalid            (),
        .s_axi_bready            (s_axi_bready),
        .s_axi_araddr            (s_axi_araddr),
        .s_axi_arvalid           (s_axi_arvalid),
        .s_axi_arready           (),
        .s_axi_rdata             (),
        .s_axi_rresp             (),
        .s_axi_rvalid            (),
        .s_axi_rready            (s_axi_rready),
        .flash_access_protection (big_prot),
        .startup_bank_swapped    (big_swap),
        .debugger_connect_enable (big_dbg),
        .bank0_base_hi           (big_bank0),
        .bank1_base_hi           (big_bank1),
        .option_code_error       (big_err)
    );
    always #4 aclk = ~aclk;
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("Error %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // read: ar held until taken, rready until rvalid answers
    task rd(input [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        while (s_axi_arready !== 1'h1) @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge aclk);
        q = s_axi_rdata;
        qr = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask
    // write: each channel dropped on its own handshake
    task wr(input [31:0] a, input [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        @(posedge aclk);
        while (s_axi_awvalid | s_axi_wvalid) begin
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            @(posedge aclk);
        end
        while (s_axi_bvalid !== 1'h1) @(posedge aclk);
        qr = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    // reboot with given codes, then invert the words to prove the hold
    task boot(input [2:0] p, input [2:0] s, input d);
        reg        sw7;
        reg        er;
        reg [15:0] e1;
        reg [15:0] e0;
        reg [15:0] f1;
        reg [15:0] f0;
        sw7 = (s == 3'h7);
        er = !((&p | ~|p) & (&s | ~|s));
        e1 = sw7 ? 16'hFFE0 : 16'hFFF0;
        e0 = sw7 ? 16'hFFF0 : 16'hFFE0;
        f1 = sw7 ? 16'hFFC0 : 16'hFFE0;
        f0 = sw7 ? 16'hFFE0 : 16'hFFC0;
        aresetn <= 1'h0;
        protect_enable_option <= {1'h0, p, 28'h0};
        startup_bank_option <= {29'h0, s};
        debug_access_option <= {31'h0, d};
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        protect_enable_option <= ~protect_enable_option;
        startup_bank_option <= ~startup_bank_option;
        debug_access_option <= ~debug_access_option;
        @(posedge aclk);
        check("prot", flash_access_protection, p != 3'h7);
        check("swap", startup_bank_swapped, sw7);
        check("bank1", bank1_base_hi, e1);
        check("bank0", bank0_base_hi, e0);
        check("dbg", debugger_connect_enable, d);
        check("err", option_code_error, er);
        check("bprot", big_prot, p != 3'h7);
        check("bswap", big_swap, sw7);
        check("bbank1", big_bank1, f1);
        check("bbank0", big_bank0, f0);
        check("bdbg", big_dbg, 1'h0);
        check("berr", big_err, er);
        rd(32'h00000000);
        check("dbgw", q, {31'h0, d});
        rd(32'h00000004);
        check("protw", q, {1'h0, p, 28'h0});
        rd(32'h0000000C);
        check("map", q, {e1, e0});
        check("mapresp", qr, 2'h0);
        rd(32'h00000010);
        check("stat", q, {27'h0, er, d, sw7, p != 3'h7, 1'h1});
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        boot(3'h0, 3'h0, 1'h0);
        boot(3'h7, 3'h7, 1'h1);
        boot(3'h0, 3'h7, 1'h1);
        boot(3'h7, 3'h0, 1'h0);
        boot(3'h5, 3'h2, 1'h0);
        rd(32'h00000014);
        check("gap", q, 32'h0);
        check("gapresp", qr, 2'h2);
        wr(32'h00000008, 32'hFFFFFFFF);
        check("bresp", qr, 2'h2);
        rd(32'h00000008);
        check("bankw", q, 32'h2);
        summarize;
    end
    // runaway guard, far beyond the hundred or so cycles needed
    initial begin
        #100000;
        bad_count = bad_count + 1;
        summarize;
    end
endmodule
